// *** hw/erxdma_params.svh ***
// Register map, field positions and reset values of the receive DMA control block
`ifndef ERXDMA_PARAMS_SVH
`define ERXDMA_PARAMS_SVH
`define ERXDMA_ADDR_W 13
`define ERXDMA_OFS_RX_BASE 13'h100c
`define ERXDMA_OFS_STATUS 13'h1014
`define ERXDMA_OFS_OPMODE 13'h1018
`define ERXDMA_OFS_IRQ_EN 13'h101c
`define ERXDMA_OFS_MISSED 13'h1020
`define ERXDMA_RST_WORD 32'h00000000
`define ERXDMA_BIT_RX_START 1
`define ERXDMA_BIT_RX_BUF_UNAVAIL 7
`define ERXDMA_BIT_RX_HALT 8
`define ERXDMA_BIT_ABN_SUM 15
`define ERXDMA_BIT_NRM_SUM 16
`define ERXDMA_LVL_LSB 26
`define ERXDMA_EVT_W 15
`define ERXDMA_NRM_MASK 15'h4045
`define ERXDMA_ABN_MASK 15'h27ba
`define ERXDMA_STICKY_MASK 15'h67ff
`define ERXDMA_IRQ_EN_MASK 32'h0001e7ff
`define ERXDMA_HOST_CNT_LSB 0
`define ERXDMA_HOST_WRAP_BIT 16
`define ERXDMA_FIFO_CNT_LSB 17
`define ERXDMA_FIFO_WRAP_BIT 28
`define ERXDMA_RESP_OKAY 2'b00
`define ERXDMA_RESP_SLVERR 2'b10
`endif

// *** hw/erxdma_pkg.sv ***
// Types shared by the receive DMA control block
package erxdma_pkg;
   typedef enum logic [3:0] {
      ST_STOPPED = 4'b0001,
      ST_RUNNING = 4'b0010,
      ST_FRAME = 4'b0100,
      ST_SUSPENDED = 4'b1000
   } erxdma_state_t;
endpackage

// *** hw/erxdma_mfc_if.sv ***
// Link between the control block and its missed-frame counters
interface erxdma_mfc_if;
   logic host_miss;
   logic fifo_loss;
   logic rd_clear;
   logic [31:0] count_word;
   modport ctl (output host_miss, output fifo_loss, output rd_clear, input count_word);
   modport cnt (input host_miss, input fifo_loss, input rd_clear, output count_word);
endinterface

// *** hw/erxdma_mfc.sv ***
// Clear-on-read missed-frame counters with wrap indicators
`include "erxdma_params.svh"
module erxdma_mfc import erxdma_pkg::*; #(
   parameter int HOST_W = 16,
   parameter int FIFO_W = 11
) (
   input wire logic clk,  // System clock
   input wire logic srst, // Synchronous reset
   erxdma_mfc_if.cnt mfc  // Events in, counter word out
);
   logic [HOST_W-1:0] host_cnt_reg, host_cnt_next;
   logic [FIFO_W-1:0] fifo_cnt_reg, fifo_cnt_next;
   logic host_wrap_reg, host_wrap_next;
   logic fifo_wrap_reg, fifo_wrap_next;

   // Read clear first, then a same-cycle miss still counts
   always_comb begin
      host_cnt_next = mfc.rd_clear ? '0 : host_cnt_reg;
      fifo_cnt_next = mfc.rd_clear ? '0 : fifo_cnt_reg;
      host_wrap_next = mfc.rd_clear ? 1'b0 : host_wrap_reg;
      fifo_wrap_next = mfc.rd_clear ? 1'b0 : fifo_wrap_reg;
      if (mfc.host_miss) begin
         host_cnt_next = host_cnt_next + 1'b1;
         if (host_cnt_next == '0) host_wrap_next = 1'b1;
      end
      if (mfc.fifo_loss) begin
         fifo_cnt_next = fifo_cnt_next + 1'b1;
         if (fifo_cnt_next == '0) fifo_wrap_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         host_cnt_reg <= '0;
         fifo_cnt_reg <= '0;
         host_wrap_reg <= 1'b0;
         fifo_wrap_reg <= 1'b0;
      end else begin
         host_cnt_reg <= host_cnt_next;
         fifo_cnt_reg <= fifo_cnt_next;
         host_wrap_reg <= host_wrap_next;
         fifo_wrap_reg <= fifo_wrap_next;
      end
   end

   // Reserved upper bits read as zero
   always_comb begin
      mfc.count_word = `ERXDMA_RST_WORD;
      mfc.count_word[`ERXDMA_HOST_CNT_LSB +: HOST_W] = host_cnt_reg;
      mfc.count_word[`ERXDMA_HOST_WRAP_BIT] = host_wrap_reg;
      mfc.count_word[`ERXDMA_FIFO_CNT_LSB +: FIFO_W] = fifo_cnt_reg;
      mfc.count_word[`ERXDMA_FIFO_WRAP_BIT] = fifo_wrap_reg;
   end

   fifo_wrap_a: assert property (@(posedge clk) disable iff (srst)
      (&fifo_cnt_reg && mfc.fifo_loss && !mfc.rd_clear) |=> (fifo_wrap_reg && fifo_cnt_reg == '0))
      else $error("fifo counter wrap not flagged");
   host_wrap_a: assert property (@(posedge clk) disable iff (srst)
      (&host_cnt_reg && mfc.host_miss && !mfc.rd_clear) |=> (host_wrap_reg && host_cnt_reg == '0))
      else $error("host counter wrap not flagged");
   read_clear_a: assert property (@(posedge clk) disable iff (srst)
      (mfc.rd_clear && !mfc.host_miss && !mfc.fifo_loss) |=> (mfc.count_word == '0))
      else $error("counters not cleared by read");
endmodule

// *** hw/erxdma_top.sv ***
// Receive DMA start/stop control, interrupt enables, system interrupt and AXI4-Lite registers
`include "erxdma_params.svh"
// How it works
// - Start bit sets receive process running
// - No owned descriptor: suspend, flag buffer unavailable
// - Start acts only from Stopped state
// - Stop waits for current frame end
// - Stop keeps next descriptor for restart
// - Stop honoured in Running or Suspended
// - Normal summary enable gates normal group
// - Abnormal summary enable gates abnormal group
// - Normal enables need normal summary enable
// - Bus error, early transmit need abnormal
// - Watchdog, receive stopped need abnormal
// - Remaining abnormal enables need abnormal enable
// - System interrupt from levels or summaries
// - Sixteen-bit host buffer miss counter
// - Eleven-bit fifo overflow and runt counter
// - Fifo counter wrap sets bit 28
// - Reading counters clears them and flags
// - Host counter wrap sets bit 16
module erxdma_top import erxdma_pkg::*; (
   input wire logic REF_CLK,                        // 250 MHz system clock
   input wire logic SRST,                           // Synchronous reset, high
   input wire logic [12:0] S_AXI_AWADDR,            // Write address
   input wire logic S_AXI_AWVALID,                  // Write address valid
   output logic S_AXI_AWREADY,                      // Write address ready
   input wire logic [31:0] S_AXI_WDATA,             // Write data
   input wire logic [3:0] S_AXI_WSTRB,              // Write byte strobes
   input wire logic S_AXI_WVALID,                   // Write data valid
   output logic S_AXI_WREADY,                       // Write data ready
   output logic [1:0] S_AXI_BRESP,                  // Write response
   output logic S_AXI_BVALID,                       // Write response valid
   input wire logic S_AXI_BREADY,                   // Write response ready
   input wire logic [12:0] S_AXI_ARADDR,            // Read address
   input wire logic S_AXI_ARVALID,                  // Read address valid
   output logic S_AXI_ARREADY,                      // Read address ready
   output logic [31:0] S_AXI_RDATA,                 // Read data
   output logic [1:0] S_AXI_RRESP,                  // Read response
   output logic S_AXI_RVALID,                       // Read data valid
   input wire logic S_AXI_RREADY,                   // Read data ready
   input wire logic [14:0] STATUS_EVT,              // Status event pulses, bits 14:0
   input wire logic TIMESTAMP_TRIGGER_FLAG,         // Time-stamp level
   input wire logic POWER_MGMT_FLAG,                // Power-management level
   input wire logic MGMT_COUNTER_FLAG,              // Management counter level
   input wire logic LINE_IFACE_FLAG,                // Line interface level
   input wire logic RX_DESC_OWNED,                  // Current descriptor owned by DMA
   input wire logic RX_FRAME_START,                 // Frame transfer begins, pulse
   input wire logic RX_FRAME_DONE,                  // Frame transfer ends, pulse
   input wire logic [31:0] RX_NEXT_DESC,            // Next descriptor at frame end
   input wire logic HOST_BUF_MISS,                  // Frame missed, no host buffer
   input wire logic FIFO_DROP,                      // Overflow or runt drop by fifo layer
   output logic SYSTEM_IRQ_OUT,                     // System interrupt, high
   output logic [3:0] RX_STATE,                     // Receive process state, one-hot
   output logic [31:0] RX_DESC_ADDR                 // Current descriptor position
);
   erxdma_mfc_if mfc_bus ();

   logic aw_hold_reg, aw_hold_next;
   logic w_hold_reg, w_hold_next;
   logic [12:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic do_write, rd_take, rd_clear;
   logic [31:0] wmask;

   logic [31:0] rx_base_reg, rx_base_next;
   logic base_fresh_reg, base_fresh_next;
   logic rx_start_stop_reg, rx_start_stop_next;
   logic [31:0] irq_en_reg, irq_en_next;
   logic [14:0] status_reg, status_next;
   logic [31:0] cur_desc_reg, cur_desc_next;
   erxdma_state_t state_reg, state_next;
   logic set_rbu, set_halt;
   logic irq_reg, irq_next;
   logic normal_summary_flag, abnormal_summary_flag;
   logic normal_summary_en, abnormal_summary_en;
   logic [3:0] level_flags;
   logic [31:0] status_word;

   // Missed-frame counters live beside the control logic
   erxdma_mfc #(.HOST_W(16), .FIFO_W(11)) u_mfc (
      .clk(REF_CLK),
      .srst(SRST),
      .mfc(mfc_bus)
   );
   assign mfc_bus.host_miss = HOST_BUF_MISS;
   assign mfc_bus.fifo_loss = FIFO_DROP;
   assign mfc_bus.rd_clear = rd_clear;

   // Summary flags and the gated interrupt request
   always_comb begin
      normal_summary_en = irq_en_reg[`ERXDMA_BIT_NRM_SUM];
      abnormal_summary_en = irq_en_reg[`ERXDMA_BIT_ABN_SUM];
      level_flags = {LINE_IFACE_FLAG, MGMT_COUNTER_FLAG, POWER_MGMT_FLAG, TIMESTAMP_TRIGGER_FLAG};
      normal_summary_flag = |(status_reg & irq_en_reg[14:0] & `ERXDMA_NRM_MASK);
      abnormal_summary_flag = |(status_reg & irq_en_reg[14:0] & `ERXDMA_ABN_MASK);
      irq_next = (|level_flags) || (normal_summary_flag && normal_summary_en)
         || (abnormal_summary_flag && abnormal_summary_en);
      status_word = `ERXDMA_RST_WORD;
      status_word[14:0] = status_reg;
      status_word[`ERXDMA_BIT_ABN_SUM] = abnormal_summary_flag;
      status_word[`ERXDMA_BIT_NRM_SUM] = normal_summary_flag;
      status_word[`ERXDMA_LVL_LSB +: 4] = level_flags;
   end

   // Bus slave: one write and one read in flight, address and data in either order
   always_comb begin
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      if (S_AXI_AWVALID && awready_reg) begin
         aw_hold_next = 1'b1;
         awaddr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_reg) begin
         w_hold_next = 1'b1;
         wdata_next = S_AXI_WDATA;
         wstrb_next = S_AXI_WSTRB;
      end
      if (bvalid_reg && S_AXI_BREADY) bvalid_next = 1'b0;
      do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         unique case (awaddr_reg[12:2])
            `ERXDMA_OFS_RX_BASE >> 2, `ERXDMA_OFS_STATUS >> 2, `ERXDMA_OFS_OPMODE >> 2,
            `ERXDMA_OFS_IRQ_EN >> 2, `ERXDMA_OFS_MISSED >> 2: bresp_next = `ERXDMA_RESP_OKAY;
            default: bresp_next = `ERXDMA_RESP_SLVERR;
         endcase
      end
      awready_next = !aw_hold_next;
      wready_next = !w_hold_next;
      if (rvalid_reg && S_AXI_RREADY) rvalid_next = 1'b0;
      rd_take = S_AXI_ARVALID && arready_reg;
      rd_clear = rd_take && (S_AXI_ARADDR[12:2] == (`ERXDMA_OFS_MISSED >> 2));
      if (rd_take) begin
         rvalid_next = 1'b1;
         rresp_next = `ERXDMA_RESP_OKAY;
         unique case (S_AXI_ARADDR[12:2])
            `ERXDMA_OFS_RX_BASE >> 2: rdata_next = rx_base_reg;
            `ERXDMA_OFS_STATUS >> 2: rdata_next = status_word;
            `ERXDMA_OFS_OPMODE >> 2: rdata_next = {30'h0, rx_start_stop_reg, 1'b0};
            `ERXDMA_OFS_IRQ_EN >> 2: rdata_next = irq_en_reg;
            `ERXDMA_OFS_MISSED >> 2: rdata_next = mfc_bus.count_word;
            default: begin
               rdata_next = `ERXDMA_RST_WORD;
               rresp_next = `ERXDMA_RESP_SLVERR;
            end
         endcase
      end
      arready_next = !rvalid_next;
      wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   end

   // Registers, status flags and the receive process
   always_comb begin
      rx_base_next = rx_base_reg;
      base_fresh_next = base_fresh_reg;
      rx_start_stop_next = rx_start_stop_reg;
      irq_en_next = irq_en_reg;
      status_next = status_reg;
      cur_desc_next = cur_desc_reg;
      state_next = state_reg;
      set_rbu = 1'b0;
      set_halt = 1'b0;
      if (do_write) begin
         unique case (awaddr_reg[12:2])
            `ERXDMA_OFS_RX_BASE >> 2: begin
               rx_base_next = (rx_base_reg & ~wmask) | (wdata_reg & wmask);
               base_fresh_next = 1'b1;
            end
            `ERXDMA_OFS_OPMODE >> 2: begin
               if (wstrb_reg[0]) rx_start_stop_next = wdata_reg[`ERXDMA_BIT_RX_START];
            end
            `ERXDMA_OFS_IRQ_EN >> 2: begin
               irq_en_next = ((irq_en_reg & ~wmask) | (wdata_reg & wmask)) & `ERXDMA_IRQ_EN_MASK;
            end
            // Status bits clear by writing one
            `ERXDMA_OFS_STATUS >> 2: status_next = status_reg & ~(wdata_reg[14:0] & wmask[14:0]);
            default: begin
            end
         endcase
      end
      unique case (state_reg)
         ST_STOPPED: begin
            if (rx_start_stop_reg) begin
               if (base_fresh_reg) cur_desc_next = rx_base_reg;
               // A base written in the start cycle stays fresh for the next start
               base_fresh_next = do_write
                  && (awaddr_reg[12:2] == (`ERXDMA_OFS_RX_BASE >> 2));
               if (RX_DESC_OWNED) state_next = ST_RUNNING;
               else begin
                  state_next = ST_SUSPENDED;
                  set_rbu = 1'b1;
               end
            end
         end
         ST_RUNNING: begin
            if (!rx_start_stop_reg) begin
               state_next = ST_STOPPED;
               set_halt = 1'b1;
            end else if (RX_FRAME_START) state_next = ST_FRAME;
            else if (!RX_DESC_OWNED) begin
               state_next = ST_SUSPENDED;
               set_rbu = 1'b1;
            end
         end
         ST_FRAME: begin
            if (RX_FRAME_DONE) begin
               cur_desc_next = RX_NEXT_DESC;
               if (!rx_start_stop_reg) begin
                  state_next = ST_STOPPED;
                  set_halt = 1'b1;
               end else state_next = ST_RUNNING;
            end
         end
         ST_SUSPENDED: begin
            if (!rx_start_stop_reg) begin
               state_next = ST_STOPPED;
               set_halt = 1'b1;
            end else if (RX_DESC_OWNED) state_next = ST_RUNNING;
         end
         default: state_next = ST_STOPPED;
      endcase
      // Events win over a same-cycle software clear
      status_next = status_next | (STATUS_EVT & `ERXDMA_STICKY_MASK);
      status_next[`ERXDMA_BIT_RX_BUF_UNAVAIL] = status_next[`ERXDMA_BIT_RX_BUF_UNAVAIL] | set_rbu;
      status_next[`ERXDMA_BIT_RX_HALT] = status_next[`ERXDMA_BIT_RX_HALT] | set_halt;
   end

   // Every output comes straight from a flop
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= `ERXDMA_RST_WORD;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `ERXDMA_RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= `ERXDMA_RESP_OKAY;
         rdata_reg <= `ERXDMA_RST_WORD;
         rx_base_reg <= `ERXDMA_RST_WORD;
         base_fresh_reg <= 1'b0;
         rx_start_stop_reg <= 1'b0;
         irq_en_reg <= `ERXDMA_RST_WORD;
         status_reg <= 15'h0000;
         cur_desc_reg <= `ERXDMA_RST_WORD;
         state_reg <= ST_STOPPED;
         irq_reg <= 1'b0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         rx_base_reg <= rx_base_next;
         base_fresh_reg <= base_fresh_next;
         rx_start_stop_reg <= rx_start_stop_next;
         irq_en_reg <= irq_en_next;
         status_reg <= status_next;
         cur_desc_reg <= cur_desc_next;
         state_reg <= state_next;
         irq_reg <= irq_next;
      end
   end

   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign SYSTEM_IRQ_OUT = irq_reg;
   assign RX_STATE = state_reg;
   assign RX_DESC_ADDR = cur_desc_reg;

   default clocking dcb @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   start_leaves_stop_a: assert property (
      (state_reg == ST_STOPPED && rx_start_stop_reg) |=> (state_reg != ST_STOPPED))
      else $error("start did not leave Stopped");
   rbu_on_suspend_a: assert property (
      (state_reg != ST_SUSPENDED) ##1 (state_reg == ST_SUSPENDED)
      |-> status_reg[`ERXDMA_BIT_RX_BUF_UNAVAIL])
      else $error("suspend without buffer unavailable flag");
   start_ignored_a: assert property (
      (state_reg == ST_SUSPENDED && rx_start_stop_reg && !RX_DESC_OWNED)
      |=> (state_reg == ST_SUSPENDED && $stable(cur_desc_reg)))
      else $error("start acted outside Stopped");
   frame_finishes_a: assert property (
      (state_reg == ST_FRAME && !RX_FRAME_DONE) |=> (state_reg == ST_FRAME))
      else $error("frame cut short");
   keep_position_a: assert property (
      (state_reg == ST_FRAME && RX_FRAME_DONE) |=> (cur_desc_reg == $past(RX_NEXT_DESC)))
      else $error("next descriptor not retained");
   stop_honoured_a: assert property (
      ((state_reg == ST_RUNNING || state_reg == ST_SUSPENDED) && !rx_start_stop_reg)
      |=> (state_reg == ST_STOPPED && status_reg[`ERXDMA_BIT_RX_HALT]))
      else $error("stop not honoured");
   summary_gate_a: assert property (
      (!normal_summary_en && !abnormal_summary_en && level_flags == 4'h0) |=> !SYSTEM_IRQ_OUT)
      else $error("interrupt without summary enable");
   irq_cause_a: assert property (
      (abnormal_summary_en && abnormal_summary_flag) |=> SYSTEM_IRQ_OUT)
      else $error("enabled abnormal summary gave no interrupt");
endmodule

// *** tb/erxdma_ring_model.sv ***
// Descriptor ring and frame source at the receive DMA's far side
module erxdma_ring_model (
   input wire logic clk,          // System clock
   input wire logic srst,         // Synchronous reset
   input wire logic give,         // Host hands descriptors over
   input wire logic go,           // One frame request, pulse
   input wire logic [31:0] cur,   // Current descriptor position
   output logic owned,            // Descriptor owned by DMA
   output logic fstart,           // Frame start pulse
   output logic fdone,            // Frame end pulse
   output logic [31:0] next_desc  // Next position, valid with fdone
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt_reg;
   logic [31:0] nd_reg;
   assign owned = give;
   // Meaningless outside fdone, so a stale value is never shown
   assign next_desc = fdone ? nd_reg : ~nd_reg;
   // Frames begin only on an owned descriptor and last 16 cycles
   always_ff @(posedge clk) begin
      fstart <= 1'b0;
      fdone <= 1'b0;
      if (srst) begin
         cnt_reg <= 5'h00;
      end else if (go && owned && cnt_reg == 5'h00) begin
         fstart <= 1'b1;
         cnt_reg <= 5'h10;
      end else if (cnt_reg != 5'h00) begin
         cnt_reg <= cnt_reg - 5'h01;
         fdone <= (cnt_reg == 5'h01);
         nd_reg <= cur + 32'h10;
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the receive DMA control block
`include "erxdma_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, give = 1'b0, go = 1'b0, hbm = 1'b0, fd = 1'b0;
   logic [12:0] awaddr = 13'h0, araddr = 13'h0;
   logic [31:0] wdata = 32'h0, rdata, desc, nxt;
   logic [14:0] evt = 15'h0;
   logic [3:0] lvl = 4'h0, state;
   logic awready, wready, bvalid, arready, rvalid, irq, owned, fstart, fdone;
   logic [1:0] bresp, rresp, wr_resp;
   int mismatches = 0, check_count = 0;
   always #2 clk = ~clk;
   erxdma_top erxdma_top_i (.REF_CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .STATUS_EVT(evt), .TIMESTAMP_TRIGGER_FLAG(lvl[0]),
      .POWER_MGMT_FLAG(lvl[1]), .MGMT_COUNTER_FLAG(lvl[2]), .LINE_IFACE_FLAG(lvl[3]),
      .RX_DESC_OWNED(owned), .RX_FRAME_START(fstart), .RX_FRAME_DONE(fdone),
      .RX_NEXT_DESC(nxt), .HOST_BUF_MISS(hbm), .FIFO_DROP(fd),
      .SYSTEM_IRQ_OUT(irq), .RX_STATE(state), .RX_DESC_ADDR(desc));
   erxdma_ring_model erxdma_ring_model_i (.clk(clk), .srst(srst), .give(give), .go(go),
      .cur(desc), .owned(owned), .fstart(fstart), .fdone(fdone), .next_desc(nxt));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait: a hung handshake ends the run
   task automatic tick(inout int n);
      n++;
      if (n > 200) begin
         chk("wait bound", 32'h0, 32'h1);
         complete_run();
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Address and data offered together, each released when taken
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      logic pa, pw, pb, ta, tw, tb;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pb) begin
         tick(n);
         @(negedge clk);
         ta = pa & awready;
         tw = pw & wready;
         tb = bvalid;
         if (bvalid) wr_resp = bresp;
         @(posedge clk);
         pa = pa & ~ta;
         pw = pw & ~tw;
         pb = pb & ~tb;
         awvalid <= pa;
         wvalid <= pw;
         bready <= pb;
      end
   endtask
   task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
      logic pa, pr, ta;
      int n;
      pa = 1'b1;
      pr = 1'b1;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (pr) begin
         tick(n);
         @(negedge clk);
         ta = pa & arready;
         pr = ~rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         pa = pa & ~ta;
         arvalid <= pa;
         rready <= pr;
      end
   endtask
   task automatic rdchk(input string what, input logic [12:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, exp, d);
   endtask
   task automatic test_regs;
      logic [31:0] d;
      logic [1:0] r;
      rdchk("irq_en reset", `ERXDMA_OFS_IRQ_EN, 32'h0);
      wr(`ERXDMA_OFS_IRQ_EN, 32'hffffffff);
      chk("write resp", 32'h0, {30'h0, wr_resp});
      rdchk("irq_en writable", `ERXDMA_OFS_IRQ_EN, 32'h0001e7ff);
      rd(13'h0ff0, d, r);
      chk("unmapped resp", 32'h2, {30'h0, r});
      wr(13'h0ff0, 32'h1);
      chk("unmapped bresp", 32'h2, {30'h0, wr_resp});
      $display("test regs done");
   endtask
   // Each event except bits 11 and 12 alone, with the wrong summary, then enabled
   task automatic test_irq;
      logic [31:0] sum;
      wr(`ERXDMA_OFS_STATUS, 32'h7fff);
      for (int i = 0; i < 15; i++) begin
         if (i == 11 || i == 12) continue;
         sum = ((15'h4045 >> i) & 15'h1) != 15'h0 ? 32'h10000 : 32'h8000;
         wr(`ERXDMA_OFS_IRQ_EN, (32'h1 << i) | (sum ^ 32'h18000));
         @(posedge clk);
         evt <= 15'h1 << i;
         @(posedge clk);
         evt <= 15'h0;
         cyc(3);
         chk("irq wrong summary", 32'h0, irq);
         wr(`ERXDMA_OFS_IRQ_EN, sum);
         cyc(2);
         chk("irq no enable", 32'h0, irq);
         wr(`ERXDMA_OFS_IRQ_EN, (32'h1 << i) | sum);
         cyc(2);
         chk("irq enabled", 32'h1, irq);
         wr(`ERXDMA_OFS_STATUS, 32'h1 << i);
         cyc(2);
         chk("irq cleared", 32'h0, irq);
      end
      wr(`ERXDMA_OFS_IRQ_EN, 32'h0);
      for (int j = 0; j < 4; j++) begin
         lvl <= 4'h1 << j;
         cyc(2);
         chk("irq level", 32'h1, irq);
         lvl <= 4'h0;
         cyc(2);
      end
      $display("test irq done");
   endtask
   task automatic test_rx;
      int n;
      n = 0;
      wr(`ERXDMA_OFS_RX_BASE, 32'h1000);
      give <= 1'b1;
      wr(`ERXDMA_OFS_OPMODE, 32'h2);
      cyc(2);
      chk("state start", 32'h2, state);
      chk("desc start", 32'h1000, desc);
      wr(`ERXDMA_OFS_OPMODE, 32'h2);
      cyc(2);
      chk("state restart", 32'h2, state);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wr(`ERXDMA_OFS_OPMODE, 32'h0);
      cyc(2);
      chk("stop deferred", 32'h4, state);
      while (state !== 4'h1) begin
         tick(n);
         cyc(1);
      end
      chk("desc saved", 32'h1010, desc);
      rdchk("status halted", `ERXDMA_OFS_STATUS, 32'h100);
      wr(`ERXDMA_OFS_STATUS, 32'h100);
      wr(`ERXDMA_OFS_OPMODE, 32'h2);
      cyc(2);
      chk("desc resumed", 32'h1010, desc);
      give <= 1'b0;
      cyc(2);
      chk("state suspended", 32'h8, state);
      rdchk("status no buffer", `ERXDMA_OFS_STATUS, 32'h80);
      wr(`ERXDMA_OFS_OPMODE, 32'h0);
      cyc(2);
      chk("stop suspended", 32'h1, state);
      $display("test rx done");
   endtask
   task automatic test_cnt;
      @(posedge clk);
      hbm <= 1'b1;
      fd <= 1'b1;
      repeat (2) @(posedge clk);
      fd <= 1'b0;
      @(posedge clk);
      hbm <= 1'b0;
      rdchk("counters", `ERXDMA_OFS_MISSED, 32'h00040003);
      rdchk("counters cleared", `ERXDMA_OFS_MISSED, 32'h0);
      hbm <= 1'b1;
      fd <= 1'b1;
      repeat (2048) @(posedge clk);
      fd <= 1'b0;
      repeat (63488) @(posedge clk);
      hbm <= 1'b0;
      rdchk("counter wrap", `ERXDMA_OFS_MISSED, 32'h10010000);
      $display("test counters done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      test_regs();
      test_irq();
      test_rx();
      test_cnt();
      complete_run();
   end
endmodule
